// [verilog/tomc_top.sv]
// Timer output/measure channel with APB registers, prescaler, counter and output flip-flop
//
// Local design decisions: the register addresses and register access over APB.
`default_nettype none
module tomc_top #(
	parameter int CNT_W = 16,
	parameter int PRESC_W = 8
) (
	// Clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	// APB slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// External pins
	input wire logic I_EXT_ENABLE,
	input wire logic I_MEASURE_EVENT,
	// Channel outputs
	output logic O_TIMER_OUT,
	output logic O_UNDERFLOW
);
	tomc_pkg::tomc_apb_req_t req;
	assign req = '{I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA};

	// Pin synchronisers and edge detection on the second stage only
	logic [2:0] ext_sync;
	logic [2:0] meas_sync;
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			ext_sync <= 3'h0;
			meas_sync <= 3'h0;
		end else begin
			ext_sync <= {ext_sync[1:0], I_EXT_ENABLE};
			meas_sync <= {meas_sync[1:0], I_MEASURE_EVENT};
		end
	end
	wire ext_rise = ext_sync[1] & ~ext_sync[2];
	wire meas_rise = meas_sync[1] & ~meas_sync[2];

	// Registers
	logic run;
	logic [2:0] mode;
	logic ff_init;
	logic [PRESC_W-1:0] presc_div;
	logic [PRESC_W-1:0] presc_cnt;
	logic [CNT_W-1:0] reload;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] measure;
	logic load_pending;
	logic ff_armed;
	logic udf_flag;
	logic meas_flag;
	logic reload_pend;

	function automatic logic hit(input tomc_pkg::tomc_apb_req_t r, input logic [7:0] off);
		hit = r.sel && r.enable && r.addr == off;
	endfunction

	wire wr_ctrl = hit(req, tomc_pkg::OFF_CTRL) && req.write;
	wire wr_presc = hit(req, tomc_pkg::OFF_PRESC) && req.write;
	wire wr_reload = hit(req, tomc_pkg::OFF_RELOAD) && req.write;
	wire wr_count = hit(req, tomc_pkg::OFF_COUNT) && req.write;
	wire wr_corr = hit(req, tomc_pkg::OFF_CORR) && req.write;
	wire wr_status = hit(req, tomc_pkg::OFF_STATUS) && req.write;
	wire rd_access = req.sel && req.enable && !req.write;
	wire wr_en_val = req.wdata[tomc_pkg::CTRL_EN_BIT];

	wire is_output = mode[2];
	wire is_single = (mode == 3'(tomc_pkg::TOMC_SINGLE)) || (mode == 3'(tomc_pkg::TOMC_DELAYED));
	wire is_cont = mode == 3'(tomc_pkg::TOMC_CONT);
	wire is_meas = (mode == 3'(tomc_pkg::TOMC_MEAS_FREE)) || (mode == 3'(tomc_pkg::TOMC_MEAS_CLEAR));

	// Count clock: one-cycle enable from the prescaler divider
	wire tick = presc_cnt == presc_div;
	wire [PRESC_W-1:0] next_presc_cnt = tick ? '0 : presc_cnt + 1'b1;

	// Underflow happens on a tick while running in an output mode with no load pending and the count zero
	wire underflow = run && tick && !load_pending && count == '0 && is_output;
	// Measure counters count upward and never underflow here
	wire stop_udf = underflow && is_single;

	// Run bit priorities
	logic next_run;
	always_comb begin
		next_run = run;
		if (ext_rise && is_output)
			next_run = 1'b1;
		if (stop_udf)
			next_run = 1'b0;
		if (wr_ctrl)
			next_run = wr_en_val;
	end
	wire start = next_run && !run;

	// Counter next value
	logic [CNT_W-1:0] next_count;
	always_comb begin
		next_count = count;
		if (start && is_output) begin
			next_count = count;
		end else if (run && tick && load_pending) begin
			next_count = reload - 1'b1;
		end else if (run && tick && reload_pend) begin
			// The ffff view after a continuous reload lasts until the next count clock
			next_count = reload - 1'b1;
		end else if (underflow && is_cont) begin
			next_count = tomc_pkg::VAL_AFTER_RELOAD;
		end else if (run && tick && is_output && !underflow) begin
			next_count = count - 1'b1;
		end else if (run && tick && is_meas) begin
			next_count = count + 1'b1;
		end
		if (run && meas_rise && mode == 3'(tomc_pkg::TOMC_MEAS_CLEAR))
			next_count = '0;
		// The wrap is silent: no carry is kept, so no overflow event exists
		if (wr_corr)
			next_count = CNT_W'(next_count + req.wdata[CNT_W-1:0]);
		if (wr_count)
			next_count = req.wdata[CNT_W-1:0];
	end

	// Capture takes the written value when it coincides with the event
	wire [CNT_W-1:0] capture_val = wr_count ? req.wdata[CNT_W-1:0] : count;

	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			run <= 1'b0;
			mode <= 3'(tomc_pkg::TOMC_MEAS_FREE);
			ff_init <= 1'b0;
			presc_div <= tomc_pkg::RST_PRESC;
			presc_cnt <= '0;
			reload <= tomc_pkg::RST_RELOAD;
			count <= tomc_pkg::RST_COUNT;
			measure <= '0;
		end else begin
			run <= next_run;
			presc_cnt <= next_presc_cnt;
			count <= next_count;
			if (wr_ctrl) begin
				mode <= req.wdata[tomc_pkg::CTRL_MODE_LSB +: 3];
				ff_init <= req.wdata[tomc_pkg::CTRL_FFINIT_BIT];
			end
			if (wr_presc)
				presc_div <= req.wdata[PRESC_W-1:0];
			if (wr_reload)
				reload <= req.wdata[CNT_W-1:0];
			if (meas_rise && run && is_meas)
				measure <= capture_val;
		end
	end

	// Load from reload waits for the first count-clock tick after start
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			load_pending <= 1'b0;
			reload_pend <= 1'b0;
			ff_armed <= 1'b0;
		end else begin
			if (start && is_output)
				load_pending <= 1'b1;
			else if (tick)
				load_pending <= 1'b0;
			reload_pend <= (underflow && is_cont) || (reload_pend && run && !tick);
			// Flip-flop is armed only at the first tick after start
			if (!next_run)
				ff_armed <= 1'b0;
			else if (run && tick)
				ff_armed <= 1'b1;
		end
	end

	// Continuous mode: ffff holds until the next count-clock tick, which brings reload minus one
	wire cont_fix = reload_pend && run;

	// Output flip-flop and event flags
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			O_TIMER_OUT <= 1'b0;
			O_UNDERFLOW <= 1'b0;
			udf_flag <= 1'b0;
			meas_flag <= 1'b0;
		end else begin
			O_UNDERFLOW <= underflow;
			if (wr_ctrl)
				O_TIMER_OUT <= req.wdata[tomc_pkg::CTRL_FFINIT_BIT];
			else if (ff_armed && (underflow || (run && tick && load_pending)))
				O_TIMER_OUT <= ~O_TIMER_OUT;
			// Set beats the write-one clear
			udf_flag <= underflow || (udf_flag && !(wr_status && req.wdata[tomc_pkg::STAT_UDF_BIT]));
			meas_flag <= (meas_rise && run && is_meas)
				|| (meas_flag && !(wr_status && req.wdata[tomc_pkg::STAT_MEAS_BIT]));
		end
	end

	// Count read: show ffff while a continuous reload is pending, else the live count
	wire [CNT_W-1:0] count_view = cont_fix ? tomc_pkg::VAL_AFTER_RELOAD : count;

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		unique case (req.addr)
			tomc_pkg::OFF_CTRL: begin
				rd_mux[tomc_pkg::CTRL_EN_BIT] = run;
				rd_mux[tomc_pkg::CTRL_MODE_LSB +: 3] = mode;
				rd_mux[tomc_pkg::CTRL_FFINIT_BIT] = ff_init;
			end
			tomc_pkg::OFF_PRESC: rd_mux[PRESC_W-1:0] = presc_div;
			tomc_pkg::OFF_RELOAD: rd_mux[CNT_W-1:0] = reload;
			tomc_pkg::OFF_COUNT: rd_mux[CNT_W-1:0] = count_view;
			tomc_pkg::OFF_MEASURE: rd_mux[CNT_W-1:0] = measure;
			tomc_pkg::OFF_STATUS: begin
				rd_mux[tomc_pkg::STAT_RUN_BIT] = run;
				rd_mux[tomc_pkg::STAT_FF_BIT] = O_TIMER_OUT;
				rd_mux[tomc_pkg::STAT_UDF_BIT] = udf_flag;
				rd_mux[tomc_pkg::STAT_MEAS_BIT] = meas_flag;
			end
			default: rd_mux = 32'h0;
		endcase
	end

	wire addr_ok = req.addr == tomc_pkg::OFF_CTRL || req.addr == tomc_pkg::OFF_PRESC
		|| req.addr == tomc_pkg::OFF_RELOAD || req.addr == tomc_pkg::OFF_COUNT
		|| req.addr == tomc_pkg::OFF_CORR || req.addr == tomc_pkg::OFF_MEASURE
		|| req.addr == tomc_pkg::OFF_STATUS;

	// Ready is a registered zero-wait answer; the access phase is one cycle after setup
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			O_PRDATA <= 32'h0;
			O_PREADY <= 1'b1;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY <= 1'b1;
			if (req.sel && !req.enable) begin
				O_PRDATA <= req.write ? 32'h0 : rd_mux;
				O_PSLVERR <= !addr_ok;
			end else if (rd_access) begin
				O_PRDATA <= O_PRDATA;
			end else if (!req.sel) begin
				// The error answer belongs to one access only
				O_PSLVERR <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// [shared/tomc_pkg.sv]
// Package for the timer output/measure channel: register map, fields, modes and resets
`default_nettype none
package tomc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_PRESC = 8'h04;
	localparam logic [7:0] OFF_RELOAD = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0c;
	localparam logic [7:0] OFF_CORR = 8'h10;
	localparam logic [7:0] OFF_MEASURE = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	// Control field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_MODE_LSB = 4;
	localparam int CTRL_FFINIT_BIT = 8;
	// Status field positions
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_FF_BIT = 1;
	localparam int STAT_UDF_BIT = 2;
	localparam int STAT_MEAS_BIT = 3;
	// Reset values, and the count shown after a continuous reload
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] RST_RELOAD = 16'h0000;
	localparam logic [7:0] RST_PRESC = 8'h00;
	localparam logic [15:0] VAL_AFTER_RELOAD = 16'hffff;
	// Operating modes
	typedef enum logic [2:0] {
		TOMC_MEAS_FREE = 3'h0,
		TOMC_MEAS_CLEAR = 3'h1,
		TOMC_SINGLE = 3'h4,
		TOMC_DELAYED = 3'h5,
		TOMC_CONT = 3'h6
	} tomc_mode_t;
	// APB request bundle
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} tomc_apb_req_t;
endpackage
`default_nettype wire

// [tb/tomc_assertions.sv]
// Port-level assertion checker for the timer channel
`default_nettype none
module tomc_checker (
	// Clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	// APB
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] O_PRDATA,
	input wire logic O_PREADY,
	input wire logic O_PSLVERR,
	// Channel
	input wire logic O_TIMER_OUT,
	input wire logic O_UNDERFLOW
);
	timeunit 1ns;
	timeprecision 1ns;
	wire acc = I_PSEL && I_PENABLE;
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RST);
	sequence s_idle2;
		!I_PSEL ##1 !I_PSEL;
	endsequence
	sequence s_quiet;
		!O_UNDERFLOW && !O_TIMER_OUT;
	endsequence
	ready_high_a: assert property (O_PREADY)
		else $error("pready low");
	udf_pulse_a: assert property (O_UNDERFLOW |=> !O_UNDERFLOW)
		else $error("underflow pulse too long");
	err_unmapped_a: assert property (acc && I_PADDR > 8'h18 |-> O_PSLVERR)
		else $error("no error on unmapped access");
	err_mapped_a: assert property (acc && I_PADDR <= 8'h18 && I_PADDR[1:0] == 2'h0 |-> !O_PSLVERR)
		else $error("error on mapped access");
	err_zero_a: assert property (acc && !I_PWRITE && O_PSLVERR |-> O_PRDATA == 32'h0)
		else $error("refused read not zero");
	hole_zero_a: assert property (acc && !I_PWRITE && I_PADDR > 8'h18 |-> O_PRDATA == 32'h0)
		else $error("unmapped read not zero");
	err_idle_a: assert property (s_idle2 |-> !O_PSLVERR)
		else $error("error while bus idle");
	quiet_start_a: assert property ($past(I_RST) |-> s_quiet ##1 s_quiet)
		else $error("outputs active after reset");
endmodule
`default_nettype wire

// [tb/tomc_pins.sv]
// Model of the external enable and measure-event pins
`default_nettype none
module tomc_pins (
	// Requests from the bench
	input wire logic clk,
	input wire logic req_en,
	input wire logic req_meas,
	// Pins, pulled low when idle
	output logic ext_en,
	output logic meas_ev
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] en_cnt = 3'h0;
	logic [2:0] ms_cnt = 3'h0;
	// Pulses last four clocks so the two-flop synchroniser always sees them
	always @(posedge clk) begin
		if (req_en) en_cnt <= 3'h4;
		else if (en_cnt != 3'h0) en_cnt <= en_cnt - 3'h1;
		if (req_meas) ms_cnt <= 3'h4;
		else if (ms_cnt != 3'h0) ms_cnt <= ms_cnt - 3'h1;
	end
	assign ext_en = en_cnt != 3'h0;
	assign meas_ev = ms_cnt != 3'h0;
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the timer channel
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	tomc_pkg::tomc_apb_req_t req = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, tout, udf, ext_en, meas_ev, err;
	logic req_en = 1'b0;
	logic req_meas = 1'b0;
	logic [15:0] c;
	int errors = 0;
	int tests_run = 0;
	int udf_n = 0;
	int n0;
	initial forever #25 clk = ~clk;
	tomc_top tomc_top_inst (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(req.sel),
		.I_PENABLE(req.enable), .I_PWRITE(req.write), .I_PADDR(req.addr),
		.I_PWDATA(req.wdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_EXT_ENABLE(ext_en), .I_MEASURE_EVENT(meas_ev), .O_TIMER_OUT(tout),
		.O_UNDERFLOW(udf));
	tomc_pins tomc_pins_inst (.clk(clk), .req_en(req_en), .req_meas(req_meas),
		.ext_en(ext_en), .meas_ev(meas_ev));
	always @(negedge clk) if (udf === 1'b1) udf_n++;
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		req.enable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		req <= '0;
		if (n >= 20) errors++;
	endtask
	task automatic wait_udf(input int lim);
		int n;
		n = 0;
		while (udf !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
		if (n >= lim) errors++;
		@(posedge clk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#500us;
		errors++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		apb(0, tomc_pkg::OFF_COUNT, 0);
		chk("count reset", rd, {16'h0, tomc_pkg::RST_COUNT});
		apb(0, 8'h1c, 0);
		chk("unmapped", {rd[30:0], err}, 32'h1);
		$display("test registers done");
		apb(1, tomc_pkg::OFF_RELOAD, 32'h5);
		apb(1, tomc_pkg::OFF_CTRL, 32'h41);
		wait_udf(40);
		apb(0, tomc_pkg::OFF_STATUS, 0);
		chk("single stop", rd & 32'h5, 32'h4);
		repeat (20) @(posedge clk);
		chk("one underflow", udf_n, 1);
		// Slow ticks leave time to read the count while it still holds ffff
		apb(1, tomc_pkg::OFF_PRESC, 32'h7);
		apb(1, tomc_pkg::OFF_CTRL, 32'h61);
		wait_udf(400);
		apb(0, tomc_pkg::OFF_COUNT, 0);
		chk("after reload", rd[15:0], tomc_pkg::VAL_AFTER_RELOAD);
		apb(0, tomc_pkg::OFF_STATUS, 0);
		chk("cont runs", rd[0], 1'b1);
		$display("test modes done");
		apb(1, tomc_pkg::OFF_CTRL, 32'h40);
		apb(1, tomc_pkg::OFF_PRESC, 32'hff);
		apb(1, tomc_pkg::OFF_RELOAD, 32'hfff8);
		apb(1, tomc_pkg::OFF_CTRL, 32'h41);
		repeat (300) @(posedge clk);
		apb(0, tomc_pkg::OFF_COUNT, 0);
		c = rd[15:0] + 16'h14;
		n0 = udf_n;
		apb(1, tomc_pkg::OFF_CORR, 32'h14);
		apb(0, tomc_pkg::OFF_COUNT, 0);
		// One tick may land between the two reads
		chk("corrected", rd[15:0] + 16'(rd[15:0] == c - 16'h1), c);
		chk("no overflow", udf_n, n0);
		wait_udf(4000);
		chk("late underflow", udf_n, n0 + 1);
		$display("test correction done");
		apb(1, tomc_pkg::OFF_CTRL, 32'h40);
		@(posedge clk);
		req_en <= 1'b1;
		@(posedge clk);
		req_en <= 1'b0;
		repeat (8) @(posedge clk);
		apb(0, tomc_pkg::OFF_STATUS, 0);
		chk("pin start", rd[1:0], 2'h1);
		apb(1, tomc_pkg::OFF_CTRL, 32'h01);
		apb(1, tomc_pkg::OFF_COUNT, 32'h1234);
		req_meas <= 1'b1;
		@(posedge clk);
		req_meas <= 1'b0;
		repeat (8) @(posedge clk);
		apb(0, tomc_pkg::OFF_MEASURE, 0);
		chk("captured", rd[15:0] - 16'(rd[15:0] == 16'h1235), 16'h1234);
		apb(0, tomc_pkg::OFF_STATUS, 0);
		chk("measure flag", rd[3], 1'b1);
		$display("test pins done");
		report_and_stop();
	end
endmodule
bind tomc_top tomc_checker tomc_checker_inst (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST),
	.I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
	.O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
	.O_TIMER_OUT(O_TIMER_OUT), .O_UNDERFLOW(O_UNDERFLOW));
`default_nettype wire
